// File: shared/sdlcft_defines.svh
/*
 * Register offsets, field positions, reset values and bit patterns of the
 * bit-oriented frame transmitter. Assumes inclusion by bare name.
 */
`ifndef SDLCFT_DEFINES_SVH
`define SDLCFT_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SDLCFT_OFS_COMMAND 4'h0
`define SDLCFT_OFS_MAIN_STATUS 4'h0
`define SDLCFT_OFS_MODE_CONFIG 4'h4
`define SDLCFT_OFS_TX_CONTROL 4'h5
`define SDLCFT_OFS_STATION_ADDR 4'h6
`define SDLCFT_OFS_FLAG_PATTERN 4'h7
`define SDLCFT_OFS_DATA 4'h8
`define SDLCFT_OFS_MISC_LINE 4'ha
`define SDLCFT_OFS_RX_STATUS 4'hb

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SDLCFT_MC_PAR_EN 0
`define SDLCFT_MC_PAR_EVEN 1
`define SDLCFT_TC_CRC_EN 0
`define SDLCFT_TC_TX_EN 3
`define SDLCFT_ML_ABORT_UNDR 2
`define SDLCFT_ML_IDLE_MARK 3
`define SDLCFT_ML_CRC_PRESET 7
`define SDLCFT_ST_TX_SPACE 2
`define SDLCFT_ST_EOM 6

// ----------------------------------------------------------------------------
// Command codes (bits 7:6 and 5:3 of the command register)
// ----------------------------------------------------------------------------
`define SDLCFT_CMD_RST_CRC 2'h2
`define SDLCFT_CMD_RST_EOM 2'h3
`define SDLCFT_CMD_ABORT 3'h1

// ----------------------------------------------------------------------------
// Reset values and patterns
// ----------------------------------------------------------------------------
`define SDLCFT_RST_MODE 8'h20
`define SDLCFT_RST_TXC 8'h60
`define SDLCFT_RST_MISC 8'h00
`define SDLCFT_FLAG 8'h7e
`define SDLCFT_EOP 8'hfe
`define SDLCFT_BCAST 8'hff
`define SDLCFT_CRC_POLY 16'h1021
`define SDLCFT_CRC_GOOD 16'h1d0f
`define SDLCFT_FIFO_DEPTH 4
`define SDLCFT_ABORT_ONES 4'h8

`endif

// File: shared/sdlcft_pkg.sv
/*
 * Types of the bit-oriented frame transmitter.
 * Assumes the defines header is compiled alongside.
 */
package sdlcft_pkg;

	// ------------------------------------------------------------------------
	// Transmit sequencer states
	// ------------------------------------------------------------------------
	typedef enum logic [5:0] {
		SDLCFT_IDLE = 6'h01,
		SDLCFT_FLAG = 6'h02,
		SDLCFT_DATA = 6'h04,
		SDLCFT_CRC = 6'h08,
		SDLCFT_ABORT = 6'h10,
		SDLCFT_MARK = 6'h20
	} sdlcft_state_t;

	// Register port request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} sdlcft_req_t;

	// Receiver summary
	typedef struct packed {
		logic frame_end;
		logic crc_ok;
		logic addr_match;
		logic abort_seen;
		logic eop_seen;
	} sdlcft_rx_t;

endpackage : sdlcft_pkg

// File: rtl/sdlcft_core.sv
/*
 * Bit-oriented frame transmitter with receive-side flag, zero deletion,
 * address compare and CRC residue check. One bit per clock on each line.
 * Assumes a register master that never waits and a line partner sampling
 * one bit per cycle.
 */
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ns
`include "sdlcft_defines.svh"
// Operation
// - Flag 01111110 opens and closes frames
// - Insert zero after five ones
// - Receiver drops zero after five ones
// - Stuffed zeros excluded from CRC
// - Flags and aborts sent unstuffed
// - One flag may close and open
// - Sixteen bits before flag are FCS
// - CRC-CCITT, inverted before sending
// - Good residue is 0001110100001111
// - Seven to thirteen ones mean abort
// - 11111110 is end of poll
// - Opening flag sent automatically; from mark idle none is sent and data waits
// - Mark idle loaded eight ones at once
// - Five to eight bits per character
// - Five-bit mode sends one to five bits
// - Optional parity bit, sense selectable
// - Address sent as data; address rx only
// - Eight-bit address, all ones broadcast
// - Entry-empty and all-empty interrupt, DMA
// - Space flag set when entry empty
// - Abort command: eight ones, flush FIFO
module sdlcft_core
	import sdlcft_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Serial line
	output logic txd,
	input wire logic rxd,
	// Events
	output logic tx_irq,
	output logic tx_dma_req,
	output sdlcft_rx_t rx_info
);

	// ------------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------------
	// One CRC-CCITT step, data bit first
	function automatic logic [15:0] crc_step(input logic [15:0] c,
		input logic b);
		logic fb;
		fb = c[15] ^ b;
		crc_step = {c[14:0], 1'b0} ^ (fb ? `SDLCFT_CRC_POLY : 16'h0000);
	endfunction : crc_step

	// Bits per character from the two length bits
	function automatic logic [3:0] char_len(input logic [1:0] sel);
		case (sel)
			2'b00: char_len = 4'h5;
			2'b01: char_len = 4'h7;
			2'b10: char_len = 4'h6;
			default: char_len = 4'h8;
		endcase
	endfunction : char_len

	// Bit reversal, so the CRC leaves its high bit first on an LSB-first line
	function automatic logic [7:0] rev8(input logic [7:0] v);
		for (int i = 0; i < 8; i++) begin
			rev8[i] = v[7 - i];
		end
	endfunction : rev8

	// Checker state after the seven flag bits folded before detection
	function automatic logic [15:0] flag_fold(input logic [15:0] c);
		flag_fold = crc_step(c, 1'b0);
		for (int i = 0; i < 6; i++) begin
			flag_fold = crc_step(flag_fold, 1'b1);
		end
	endfunction : flag_fold

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	sdlcft_req_t req;
	logic [7:0] mode_config_reg_r;
	logic [7:0] tx_control_reg_r;
	logic [7:0] station_address_reg_r;
	logic [7:0] flag_pattern_reg_r;
	logic [7:0] misc_line_control_reg_r;
	logic eom_r;
	logic abort_cmd;
	logic crc_reset_cmd;
	logic data_wr;

	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
	assign data_wr = req.wr && req.addr == `SDLCFT_OFS_DATA;
	assign abort_cmd = req.wr && req.addr == `SDLCFT_OFS_COMMAND
		&& req.wdata[5:3] == `SDLCFT_CMD_ABORT;
	assign crc_reset_cmd = req.wr && req.addr == `SDLCFT_OFS_COMMAND
		&& req.wdata[7:6] == `SDLCFT_CMD_RST_CRC;

	// Configuration writes
	always_ff @(posedge mclk) begin
		if (rst) begin
			mode_config_reg_r <= `SDLCFT_RST_MODE;
			tx_control_reg_r <= `SDLCFT_RST_TXC;
			station_address_reg_r <= 8'h00;
			flag_pattern_reg_r <= `SDLCFT_FLAG;
			misc_line_control_reg_r <= `SDLCFT_RST_MISC;
		end else if (req.wr) begin
			case (req.addr)
				`SDLCFT_OFS_MODE_CONFIG: mode_config_reg_r <= req.wdata;
				`SDLCFT_OFS_TX_CONTROL: tx_control_reg_r <= req.wdata;
				`SDLCFT_OFS_STATION_ADDR: station_address_reg_r <= req.wdata;
				`SDLCFT_OFS_FLAG_PATTERN: flag_pattern_reg_r <= req.wdata;
				`SDLCFT_OFS_MISC_LINE: misc_line_control_reg_r <= req.wdata;
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Transmit FIFO
	// ------------------------------------------------------------------------
	logic [7:0] fifo_mem [0:`SDLCFT_FIFO_DEPTH-1];
	logic [1:0] wr_ptr_r;
	logic [1:0] rd_ptr_r;
	logic [2:0] count_r;
	logic fifo_pop;
	logic fifo_push;
	logic fifo_empty;
	logic fifo_full;

	assign fifo_empty = count_r == 3'h0;
	assign fifo_full = count_r == 3'h4;
	assign fifo_push = data_wr && !fifo_full;

	// Write-side storage; a write to a full FIFO is dropped
	always_ff @(posedge mclk) begin
		if (fifo_push) begin
			fifo_mem[wr_ptr_r] <= req.wdata;
		end
	end

	// Pointers; abort flushes the FIFO
	always_ff @(posedge mclk) begin
		if (rst || abort_cmd) begin
			wr_ptr_r <= 2'h0;
			rd_ptr_r <= 2'h0;
			count_r <= 3'h0;
		end else begin
			wr_ptr_r <= wr_ptr_r + 2'(fifo_push);
			rd_ptr_r <= rd_ptr_r + 2'(fifo_pop);
			count_r <= count_r + 3'(fifo_push) - 3'(fifo_pop);
		end
	end

	// Entry location empty / whole FIFO empty
	assign tx_dma_req = !fifo_full;
	assign tx_irq = fifo_empty;

	// ------------------------------------------------------------------------
	// Transmit sequencer and shift register
	// ------------------------------------------------------------------------
	sdlcft_state_t state_r;
	logic [8:0] shift_r;
	logic [3:0] bits_r;
	logic [15:0] tx_crc_r;
	logic [2:0] ones_r;
	logic stuff_r;
	logic txd_r;
	logic tx_en;
	logic raw_bit;
	logic stuffable;
	logic [3:0] len;
	logic [7:0] head;
	logic par;
	logic [8:0] char_word;
	logic [3:0] char_bits;
	logic shift_done;

	assign tx_en = tx_control_reg_r[`SDLCFT_TC_TX_EN];
	assign len = char_len(tx_control_reg_r[6:5]);
	assign head = fifo_mem[rd_ptr_r];
	assign raw_bit = shift_r[0];
	assign stuffable = state_r == SDLCFT_DATA || state_r == SDLCFT_CRC;
	// Shift register advances unless a stuffed zero occupies the line
	assign shift_done = bits_r == 4'h1 && !stuff_r;

	logic eom_cmd;
	logic eom_clr_pend_r;
	logic eom_eff;
	logic char_edge;
	logic crc_lo_r;
	logic [15:0] crc_next;

	assign eom_cmd = req.wr && req.addr == `SDLCFT_OFS_COMMAND
		&& req.wdata[7:6] == `SDLCFT_CMD_RST_EOM;
	assign char_edge = !stuff_r && (bits_r == 4'h0 || shift_done);
	// EOM latch as it will stand once a pending reset is applied
	assign eom_eff = eom_r && !eom_clr_pend_r && !eom_cmd;
	// CRC including the bit on the line now; used when the CRC is loaded
	assign crc_next = tx_control_reg_r[`SDLCFT_TC_CRC_EN]
		? crc_step(tx_crc_r, raw_bit) : tx_crc_r;

	// EOM reset waits for the next character boundary
	always_ff @(posedge mclk) begin
		if (rst) begin
			eom_clr_pend_r <= 1'b0;
		end else if (char_edge && !abort_cmd) begin
			eom_clr_pend_r <= 1'b0;
		end else if (eom_cmd) begin
			eom_clr_pend_r <= 1'b1;
		end
	end

	// Character build: right justified data, optional parity
	always_comb begin
		logic [7:0] m;
		m = 8'hff >> (4'h8 - len);
		par = ^(head & m) ^ ~mode_config_reg_r[`SDLCFT_MC_PAR_EVEN];
		char_word = {1'b0, head & m};
		char_bits = len;
		// Five-bit mode: highest zero below leading ones marks length
		if (len == 4'h5) begin
			char_bits = 4'h5;
			if (head[7:4] == 4'hf) begin
				char_bits = 4'h1;
			end else if (head[7:5] == 3'h7) begin
				char_bits = 4'h2;
			end else if (head[7:6] == 2'h3) begin
				char_bits = 4'h3;
			end else if (head[7] == 1'b1) begin
				char_bits = 4'h4;
			end
			char_word = {1'b0, head & (8'hff >> (4'h8 - char_bits))};
		end
		if (mode_config_reg_r[`SDLCFT_MC_PAR_EN]) begin
			char_word[char_bits] = par;
			char_bits = char_bits + 4'h1;
		end
	end

	assign fifo_pop = !stuff_r && tx_en && fifo_empty == 1'b0
		&& (state_r == SDLCFT_FLAG || state_r == SDLCFT_DATA)
		&& (bits_r == 4'h0 || shift_done) && !abort_cmd;

	// Sequencer: FIFO to shifter to zero inserter to line
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_r <= SDLCFT_IDLE;
			shift_r <= 9'h1ff;
			bits_r <= 4'h0;
			eom_r <= 1'b1;
			crc_lo_r <= 1'b0;
		end else if (abort_cmd) begin
			state_r <= SDLCFT_ABORT;
			shift_r <= 9'h1ff;
			bits_r <= `SDLCFT_ABORT_ONES;
			crc_lo_r <= 1'b0;
		end else if (!stuff_r && (bits_r == 4'h0 || shift_done)) begin
			if (eom_clr_pend_r || eom_cmd) begin
				eom_r <= 1'b0;
			end
			if (fifo_pop) begin
				state_r <= SDLCFT_DATA;
				shift_r <= char_word;
				bits_r <= char_bits;
			end else if (state_r == SDLCFT_DATA && !eom_eff) begin
				// Underrun ends the frame with CRC or abort; set wins
				eom_r <= 1'b1;
				crc_lo_r <= !misc_line_control_reg_r[`SDLCFT_ML_ABORT_UNDR];
				state_r <= misc_line_control_reg_r[`SDLCFT_ML_ABORT_UNDR]
					? SDLCFT_ABORT : SDLCFT_CRC;
				shift_r <= misc_line_control_reg_r[`SDLCFT_ML_ABORT_UNDR]
					? 9'h1ff : {1'b0, rev8(~crc_next[15:8])};
				bits_r <= 4'h8;
			end else if (state_r == SDLCFT_CRC && crc_lo_r) begin
				// Second CRC byte, high bit first
				crc_lo_r <= 1'b0;
				shift_r <= {1'b0, rev8(~tx_crc_r[7:0])};
				bits_r <= 4'h8;
			end else if (tx_en && !(state_r == SDLCFT_IDLE
				&& misc_line_control_reg_r[`SDLCFT_ML_IDLE_MARK])) begin
				// Opening, closing and idle flags, back to back safe
				state_r <= SDLCFT_FLAG;
				shift_r <= {1'b0, flag_pattern_reg_r};
				bits_r <= 4'h8;
			end else begin
				// Mark idle: eight ones at a time
				state_r <= SDLCFT_IDLE;
				shift_r <= 9'h1ff;
				bits_r <= 4'h8;
			end
		end else if (!stuff_r) begin
			shift_r <= {1'b1, shift_r[8:1]};
			bits_r <= bits_r - 4'h1;
		end
	end

	// Zero inserter on data and CRC only
	always_ff @(posedge mclk) begin
		if (rst || !stuffable) begin
			ones_r <= 3'h0;
			stuff_r <= 1'b0;
		end else if (stuff_r) begin
			ones_r <= 3'h0;
			stuff_r <= 1'b0;
		end else if (bits_r != 4'h0 && raw_bit) begin
			ones_r <= ones_r + 3'h1;
			stuff_r <= ones_r == 3'h4;
		end else begin
			ones_r <= 3'h0;
		end
	end

	// Line output; a stuffed zero bypasses the CRC
	always_ff @(posedge mclk) begin
		if (rst) begin
			txd_r <= 1'b1;
		end else begin
			txd_r <= stuff_r ? 1'b0 : (bits_r != 4'h0 ? raw_bit : 1'b1);
		end
	end
	assign txd = txd_r;

	// Transmit CRC over data bits only, inverted when sent
	always_ff @(posedge mclk) begin
		if (rst || crc_reset_cmd) begin
			tx_crc_r <= {16{misc_line_control_reg_r[`SDLCFT_ML_CRC_PRESET]}};
		end else if (state_r == SDLCFT_DATA && !stuff_r && bits_r != 4'h0
			&& tx_control_reg_r[`SDLCFT_TC_CRC_EN]) begin
			tx_crc_r <= crc_step(tx_crc_r, raw_bit);
		end
	end

	// ------------------------------------------------------------------------
	// Receiver: zero deletion, flags, abort, end of poll, address, CRC
	// ------------------------------------------------------------------------
	logic [7:0] rx_hist_r;
	logic [3:0] rx_ones_r;
	logic [15:0] rx_crc_r;
	logic [7:0] rx_byte_r;
	logic [3:0] rx_cnt_r;
	logic rx_addr_done_r;
	logic rx_in_frame_r;
	logic flag_hit;
	logic del_zero;
	logic [7:0] rx_hist;
	sdlcft_rx_t rx_r;

	assign rx_hist = {rxd, rx_hist_r[7:1]};
	assign flag_hit = rx_hist == `SDLCFT_FLAG;
	assign del_zero = !rxd && rx_ones_r == 4'h5;

	// Receive history and run of ones
	always_ff @(posedge mclk) begin
		if (rst) begin
			rx_hist_r <= 8'h00;
			rx_ones_r <= 4'h0;
		end else begin
			rx_hist_r <= rx_hist;
			rx_ones_r <= rxd ? (rx_ones_r == 4'hf ? 4'hf : rx_ones_r + 4'h1)
				: 4'h0;
		end
	end

	// Frame tracking, address compare and residue check
	always_ff @(posedge mclk) begin
		if (rst) begin
			rx_crc_r <= 16'hffff;
			rx_byte_r <= 8'h00;
			rx_cnt_r <= 4'h0;
			rx_addr_done_r <= 1'b0;
			rx_in_frame_r <= 1'b0;
			rx_r <= '0;
		end else begin
			rx_r.frame_end <= 1'b0;
			rx_r.eop_seen <= rx_hist == `SDLCFT_EOP && !rx_in_frame_r;
			if (rx_ones_r == 4'h6 && rxd) begin
				rx_r.abort_seen <= 1'b1;
				rx_in_frame_r <= 1'b0;
			end else if (flag_hit) begin
				// Closing flag may open the next frame
				// Only frames holding at least an address are reported
				if (rx_in_frame_r && rx_addr_done_r) begin
					rx_r.frame_end <= 1'b1;
					// Residue test past the folded flag bits
					rx_r.crc_ok <= rx_crc_r == flag_fold(`SDLCFT_CRC_GOOD);
				end
				rx_in_frame_r <= 1'b1;
				rx_r.abort_seen <= 1'b0;
				rx_crc_r <= {16{misc_line_control_reg_r[`SDLCFT_ML_CRC_PRESET]}};
				rx_cnt_r <= 4'h0;
				rx_addr_done_r <= 1'b0;
			end else if (rx_in_frame_r && !del_zero) begin
				rx_crc_r <= crc_step(rx_crc_r, rxd);
				rx_byte_r <= {rxd, rx_byte_r[7:1]};
				if (!rx_addr_done_r) begin
					rx_cnt_r <= rx_cnt_r + 4'h1;
					if (rx_cnt_r == 4'h7) begin
						// Eight-bit address, broadcast accepted
						rx_addr_done_r <= 1'b1;
						rx_r.addr_match <= {rxd, rx_byte_r[7:1]} ==
							station_address_reg_r || {rxd, rx_byte_r[7:1]}
							== `SDLCFT_BCAST;
					end
				end
			end
		end
	end
	assign rx_info = rx_r;

	// ------------------------------------------------------------------------
	// Read data, one cycle after the strobe
	// ------------------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (req.rd) begin
			case (req.addr)
				`SDLCFT_OFS_MAIN_STATUS: reg_rdata <= {1'b0, eom_r, 3'h0,
					!fifo_full, 2'h0};
				`SDLCFT_OFS_MODE_CONFIG: reg_rdata <= mode_config_reg_r;
				`SDLCFT_OFS_TX_CONTROL: reg_rdata <= tx_control_reg_r;
				`SDLCFT_OFS_STATION_ADDR: reg_rdata <= station_address_reg_r;
				`SDLCFT_OFS_FLAG_PATTERN: reg_rdata <= flag_pattern_reg_r;
				`SDLCFT_OFS_MISC_LINE: reg_rdata <= misc_line_control_reg_r;
				`SDLCFT_OFS_RX_STATUS: reg_rdata <= {3'h0, rx_r};
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

endmodule : sdlcft_core

// File: verification/sdlcft_core_sva.sv
/* Port checker of the frame transmitter core.
 * Assumes it is bound to the core and shares its clock and reset. */
`timescale 1ns/1ns
module sdlcft_core_sva
	import sdlcft_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Line and events
	input wire logic txd,
	input wire logic rxd,
	input wire logic tx_irq,
	input wire logic tx_dma_req,
	input wire sdlcft_rx_t rx_info
);
	logic [7:0] tx_hist_r;
	logic [7:0] rx_hist_r;
	logic mark_r;
	logic tx_flag;
	logic rx_flag;
	logic abort_cmd;

	// ------------------------------
	// Helper logic
	// ------------------------------
	// Last eight line bits, oldest at bit 0
	always_ff @(posedge mclk) begin
		tx_hist_r <= {txd, tx_hist_r[7:1]};
		rx_hist_r <= {rxd, rx_hist_r[7:1]};
	end
	// Idle-mark setting as last written
	always_ff @(posedge mclk) begin
		if (rst)
			mark_r <= 1'b0;
		else if (reg_wr && reg_addr == 4'ha)
			mark_r <= reg_wdata[3];
	end
	assign tx_flag = tx_hist_r == 8'h7e;
	assign rx_flag = rx_hist_r == 8'h7e;
	assign abort_cmd = reg_wr && reg_addr == 4'h0 && reg_wdata[5:3] == 3'h1;

	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	// ------------------------------
	// Assertions
	// ------------------------------
	AST_SPACE_FLAG: assert property (
		reg_rd && reg_addr == 4'h0 |=> reg_rdata[2] == $past(tx_dma_req))
		else $error("space flag differs from entry state");
	AST_EMPTY_ENTRY: assert property (tx_irq |-> tx_dma_req)
		else $error("empty without entry request");
	AST_FILL: assert property (
		reg_wr && reg_addr == 4'h8 && tx_irq |-> ##[1:2] !tx_irq)
		else $error("empty event stuck after data write");
	AST_ABORT_ONES: assert property (abort_cmd |-> ##[1:30] txd [*8])
		else $error("no eight ones after abort");
	AST_ABORT_FLUSH: assert property (abort_cmd |-> ##[1:3] tx_irq)
		else $error("fifo not flushed by abort");
	AST_OPEN_FLAG: assert property (
		reg_wr && reg_addr == 4'h5 && reg_wdata[3] && !mark_r && tx_irq
		|-> ##[1:60] tx_flag)
		else $error("no flag after enable");
	AST_RX_ABORT: assert property (
		!rxd ##1 rxd [*7] |-> ##[0:3] rx_info.abort_seen)
		else $error("seven ones not seen as abort");
	AST_END_FLAG: assert property (
		rx_info.frame_end |-> rx_flag || $past(rx_flag) ||
		$past(rx_flag, 2) || $past(rx_flag, 3))
		else $error("frame end without flag");
	AST_END_PULSE: assert property (
		rx_info.frame_end |=> !rx_info.frame_end)
		else $error("frame end longer than a cycle");

	// Main scenarios reached
	COV_GOOD: cover property (rx_info.frame_end && rx_info.crc_ok);
	COV_ABORT: cover property (abort_cmd);
	COV_FULL: cover property (!tx_dma_req);
endmodule : sdlcft_core_sva

bind sdlcft_core sdlcft_core_sva u_sva (.mclk(mclk), .rst(rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .txd(txd), .rxd(rxd),
	.tx_irq(tx_irq), .tx_dma_req(tx_dma_req), .rx_info(rx_info));

// File: verification/sdlcft_station.sv
/* Remote line station: deletes stuffed zeros, frames on flags, counts
 * aborts and loops the line back. Assumes one bit per clock, idle high. */
`timescale 1ns/1ns
module sdlcft_station (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Line
	input wire logic txd,
	output logic rxd
);
	int ones;
	int frames;
	int aborts;
	logic bits[$];
	logic fr[$];

	// Line looped back to the core receiver
	assign rxd = txd;

	// Zero deletion, flag framing and abort count
	always @(posedge mclk) begin
		if (rst) begin
			ones = 0;
			frames = 0;
			aborts = 0;
			bits = {};
		end else if (txd) begin
			bits.push_back(1'b1);
			if (ones == 6)
				aborts++;
			ones++;
		end else begin
			if (ones >= 6) begin
				if (ones == 6 && bits.size() > 7) begin
					fr = bits[0:$-7];
					frames++;
				end
				bits = {};
			end else if (ones != 5)
				bits.push_back(1'b0);
			ones = 0;
		end
	end
endmodule : sdlcft_station

// File: verification/tb_top.sv
/* Testbench of the frame transmitter: register tasks, random frames
 * through a looped-back station. Assumes core, checker and station. */
`timescale 1ns/1ns
`include "sdlcft_defines.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
	$display("Error %0t: got %h exp %h", $time, g, e); end end
module tb_top;
	import sdlcft_pkg::*;
	logic mclk, rst, reg_wr, reg_rd, txd, rxd, tx_irq, tx_dma_req;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, d;
	sdlcft_rx_t rx_info, last_rx;
	int n_fail, check_count, cyc, fr0;
	logic [7:0] exp_q[$];
	logic [3:0] ra[6] = '{4'h0, 4'h4, 4'h5, 4'h7, 4'ha, 4'hf};
	logic [7:0] rv[6] = '{8'h44, 8'h20, 8'h60, 8'h7e, 8'h00, 8'h00};
	logic [7:0] fa[3] = '{8'h35, 8'hff, 8'h12};
	logic fm[3] = '{1'b1, 1'b1, 1'b0};

	sdlcft_core DUT (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .txd(txd), .rxd(rxd), .tx_irq(tx_irq),
		.tx_dma_req(tx_dma_req), .rx_info(rx_info));
	sdlcft_station st (.mclk(mclk), .rst(rst), .txd(txd), .rxd(rxd));

	// ------------------------------
	// Clock, timeout, frame monitor
	// ------------------------------
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		if (rx_info.frame_end === 1'b1)
			last_rx <= rx_info;
		if (cyc == 20000) begin
			n_fail++;
			report_and_stop();
		end
	end

	// ------------------------------
	// Tasks and functions
	// ------------------------------
	task wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr
	task rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd
	function automatic logic [15:0] crc_run(input logic q[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (q[i])
			c = {c[14:0], 1'b0} ^ ((c[15] ^ q[i]) ? 16'h1021 : 16'h0);
		return c;
	endfunction : crc_run
	task send(input int n, input int p, input logic [7:0] a, input logic m);
		int t;
		logic q[$];
		fr0 = st.frames;
		last_rx = '0;
		exp_q = {};
		wr(4'h0, 8'h80);
		for (int i = 0; i < n; i++) begin
			exp_q.push_back((i == 0) ? a : 8'($urandom_range(255)));
			wr(4'h8, exp_q[i]);
			if (i == 0)
				wr(4'h0, 8'hc0);
		end
		t = 0;
		while (st.frames == fr0 && t < 600) begin
			@(posedge mclk);
			t++;
		end
		repeat (6) @(posedge mclk);
		q = st.fr;
		`CHK(q.size(), (8 + p) * n + 16)
		foreach (exp_q[i]) begin
			for (int k = 0; k < 8; k++)
				`CHK(q[i * (8 + p) + k], exp_q[i][k])
			if (p)
				`CHK(q[i * 9 + 8], ^exp_q[i])
		end
		if (!p) begin
			`CHK(crc_run(q), `SDLCFT_CRC_GOOD)
			`CHK(last_rx.crc_ok, 1'b1)
			`CHK(last_rx.addr_match, m)
		end
	endtask : send
	task report_and_stop;
		$display("Checks %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : report_and_stop

	// Main sequence
	initial begin
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		last_rx = '0;
		void'($urandom(32'hcc06));
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		foreach (ra[i]) begin
			rd(ra[i], d);
			`CHK(d, rv[i])
		end
		wr(4'h4, 8'h20);
		wr(4'h7, 8'h7e);
		wr(4'h6, 8'h35);
		wr(4'ha, 8'h88);
		wr(4'h5, 8'h69);
		repeat (20) begin
			@(posedge mclk);
			#1 `CHK(txd, 1'b1)
		end
		wr(4'ha, 8'h80);
		repeat (10) @(posedge mclk);
		foreach (fa[i])
			send($urandom_range(4, 1), 0, fa[i], fm[i]);
		wr(4'h4, 8'h23);
		send(2, 1, 8'h35, 1'b1);
		wr(4'h4, 8'h20);
		// Fill with the transmitter off, then flush by abort
		wr(4'h5, 8'h61);
		repeat (5) wr(4'h8, 8'($urandom_range(255)));
		rd(4'h0, d);
		`CHK(d[2], 1'b0)
		`CHK(tx_dma_req, 1'b0)
		wr(4'h0, 8'h08);
		repeat (2) @(posedge mclk);
		#1 `CHK(tx_irq, 1'b1)
		// Abort in mid-frame
		wr(4'h5, 8'h69);
		wr(4'h0, 8'h80);
		fr0 = st.aborts;
		repeat (3) wr(4'h8, 8'h00);
		repeat (12) @(posedge mclk);
		wr(4'h0, 8'h08);
		repeat (40) @(posedge mclk);
		`CHK(st.aborts, fr0 + 1)
		report_and_stop();
	end
endmodule : tb_top
